/* design/cir_pkg.sv */
/*
 * Shared constants and layouts for the card identification and card data
 * register bank: APB byte addresses, fixed field codes, flag bit positions,
 * status bit positions and the packed layouts of both 128-bit registers.
 * Assumes a 32-bit APB with byte addresses and one register word per offset.
 */
package cir_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register map, byte addresses. Each 128-bit register spans four words,
    // word 0 holding bits [31:0] and word 3 holding bits [127:96].
    localparam logic [7:0] CIR_BASE_IDENT = 8'h00;
    localparam logic [7:0] CIR_BASE_DATA = 8'h10;
    localparam logic [7:0] CIR_OFF_STATUS = 8'h20;

    // Fixed field codes of the card data register.
    localparam logic [1:0] CIR_LAYOUT_VERSION = 2'h1;
    localparam logic [7:0] CIR_READ_ACCESS_TIME = 8'h0E;
    localparam logic [7:0] CIR_READ_ACCESS_CYCLES = 8'h00;
    localparam logic [7:0] CIR_TRANSFER_RATE = 8'h5A;
    localparam logic [11:0] CIR_COMMAND_CLASSES = 12'h5B5;
    localparam logic [3:0] CIR_BLOCK_LENGTH_CODE = 4'h9;
    localparam logic [6:0] CIR_SECTOR_SIZE = 7'h7F;
    localparam logic [6:0] CIR_PROTECT_SPAN = 7'h00;
    localparam logic [2:0] CIR_WRITE_SPEED = 3'h2;
    localparam logic [1:0] CIR_FILE_FORMAT = 2'h0;
    localparam logic CIR_ERASE_ENABLE = 1'b1;

    // Positions of the flags inside data word 0; format is fixed at zero, the others are host-programmable.
    localparam int CIR_FORMAT_BIT = 15;
    localparam int CIR_COPY_BIT = 14;
    localparam int CIR_PERM_BIT = 13;
    localparam int CIR_TEMP_BIT = 12;

    // Status word bit positions.
    localparam int CIR_ST_CRC_READY = 0;
    localparam int CIR_ST_COPY_LOCK = 1;
    localparam int CIR_ST_PERM_LOCK = 2;
    localparam int CIR_ST_PROTECT = 3;

    // Checksum engine: seven-bit code, x^7 + x^3 + 1, over the upper 120 bits.
    localparam int CIR_CRC_BITS = 120;
    localparam logic [6:0] CIR_CRC_POLY = 7'h09;
    localparam logic [6:0] CIR_CRC_LAST = 7'h77;

    ////////////////////////////////////////////////////////////////////////////
    // Card identification layout, most significant field first.
    typedef struct packed {
        logic [7:0] maker_code;
        logic [15:0] application_code;
        logic [39:0] product_name;
        logic [7:0] product_revision;
        logic [31:0] unit_serial;
        logic [3:0] reserved0;
        logic [11:0] manufacture_date;
        logic [6:0] crc;
        logic fixed_one;
    } cir_ident_s;

    // Card specific data layout, most significant field first.
    typedef struct packed {
        logic [1:0] layout_version;
        logic [5:0] reserved0;
        logic [7:0] read_access_time_code;
        logic [7:0] read_access_clock_cycles;
        logic [7:0] max_transfer_rate;
        logic [11:0] supported_command_classes;
        logic [3:0] max_read_block_length;
        logic partial_read_allowed;
        logic write_misalign_allowed;
        logic read_misalign_allowed;
        logic driver_stage_present;
        logic [5:0] reserved1;
        logic [21:0] capacity;
        logic reserved2;
        logic single_block_erase_enable;
        logic [6:0] erase_sector_size;
        logic [6:0] protect_group_span;
        logic protect_group_enable;
        logic [1:0] reserved3;
        logic [2:0] write_speed_factor;
        logic [3:0] max_write_block_length;
        logic partial_write_allowed;
        logic [4:0] reserved4;
        logic format_group_flag;
        logic copy_flag;
        logic permanent_protection;
        logic temporary_protection;
        logic [1:0] file_format;
        logic [1:0] reserved5;
        logic [6:0] crc;
        logic fixed_one;
    } cir_data_s;

endpackage : cir_pkg

/* design/cir_crc7.sv */
/*
 * Serial seven-bit checksum engine. It captures a 120-bit message on start
 * and shifts it in most significant bit first, one bit per clock.
 * Assumes start is a one-cycle pulse from logic on the same clock; a start
 * during a run abandons that run and begins again on the new message.
 */
module cir_crc7
    import cir_pkg::*;
(
    input wire logic clock, // System clock.
    input wire logic reset, // Synchronous reset, active high.
    input wire logic start, // Pulse: capture message and begin.
    input wire logic [CIR_CRC_BITS-1:0] message, // Bits to be covered.
    output logic [6:0] crc, // Result of the last finished run.
    output logic busy // High while a run is in progress.
);

    ////////////////////////////////////////////////////////////////////////////
    logic [CIR_CRC_BITS-1:0] shift_r;
    logic [6:0] acc_r;
    logic [6:0] count_r;
    logic feedback;
    logic [6:0] acc_nxt;

    // Division step of the generator; the feedback taps land on bits 3 and 0.
    assign feedback = acc_r[6] ^ shift_r[CIR_CRC_BITS-1];
    assign acc_nxt = {acc_r[5:0], 1'b0} ^ ({7{feedback}} & CIR_CRC_POLY);

    // One bit per cycle; the result only moves when a run completes, so the
    // previous value stays readable throughout a recalculation.
    always_ff @(posedge clock) begin
        if (reset) begin
            shift_r <= '0;
            acc_r <= 7'h00;
            count_r <= 7'h00;
            crc <= 7'h00;
            busy <= 1'b0;
        end else if (start) begin
            shift_r <= message;
            acc_r <= 7'h00;
            count_r <= CIR_CRC_LAST;
            busy <= 1'b1;
        end else if (busy) begin
            shift_r <= {shift_r[CIR_CRC_BITS-2:0], 1'b0};
            acc_r <= acc_nxt;
            count_r <= count_r - 7'h01;
            if (count_r == 7'h00) begin
                busy <= 1'b0;
                crc <= acc_nxt;
            end
        end
    end

endmodule : cir_crc7

/* design/cir_regs.sv */
/*
 * Card identification and card specific data register bank with an APB
 * slave. Both 128-bit registers are built from fixed codes and production
 * parameters; checksums are computed in hardware after reset and after each
 * change to the host-programmable flags.
 * Assumes an APB master on the same clock and a synchronous active-high reset.
 */
// The APB register port and the address map are this design's own decisions.
////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - 128-bit identification register, host read only.
// - Maker, application, name, revision at fixed slices.
// - Serial, reserved nibble, date fixed per unit.
// - Checksum over upper bits, bit zero one.
// - Data register version one, capacity, no driver.
// - Access time 0x0E, zero cycles, speed factor 2.
// - Transfer rate 0x5A, command classes 0x5B5.
// - Read and write block length code 9.
// - No partial or misaligned block access.
// - Single block erase on, sector size 0x7F.
// - No group write protection offered.
// - Read-only ignore writes, one-time flags program once.
module cir_regs
    import cir_pkg::*;
#(
    parameter logic [7:0] MAKER_CODE = 8'h5C, // Arbitrary neutral value.
    parameter logic [15:0] APPLICATION_CODE = 16'h7E21, // Arbitrary neutral value.
    parameter logic [39:0] PRODUCT_NAME = 40'h41_42_43_44_45, // Arbitrary value.
    parameter logic [7:0] PRODUCT_REVISION = 8'h11, // Arbitrary neutral value.
    parameter logic [31:0] UNIT_SERIAL = 32'h0000_0001, // Set at production.
    parameter logic [11:0] MANUFACTURE_DATE = 12'h001, // Set at production.
    parameter logic [21:0] CAPACITY = 22'h003A4F // Size code of the card.
) (
    input wire logic clock, // 40 MHz system clock.
    input wire logic reset, // Synchronous reset, active high.
    input wire logic psel, // APB select.
    input wire logic penable, // APB access phase.
    input wire logic pwrite, // APB direction, high for write.
    input wire logic [7:0] paddr, // APB byte address.
    input wire logic [31:0] pwdata, // APB write data.
    output logic pready, // APB ready, registered.
    output logic [31:0] prdata, // APB read data, registered.
    output logic pslverr, // APB error for unmapped address.
    output logic write_protect // Card write protected, registered.
);

    ////////////////////////////////////////////////////////////////////////////
    // State.
    logic boot_r;
    logic restart_r;
    logic copy_r;
    logic perm_r;
    logic temp_r;
    logic copy_lock_r;
    logic perm_lock_r;
    logic id_busy;
    logic data_busy;
    logic [6:0] id_crc;
    logic [6:0] data_crc;
    cir_ident_s ident;
    cir_data_s card_data;
    logic [31:0] id_word [4];
    logic [31:0] data_word [4];

    ////////////////////////////////////////////////////////////////////////////
    // Address decode and bus handshake terms.
    logic hit_id;
    logic hit_data;
    logic hit_status;
    logic hit_any;
    logic crc_ready;
    logic take_nxt;
    logic wr_fire;
    logic rd_fire;
    logic wr_flags;
    logic [31:0] status_word;
    logic [31:0] read_word;

    assign hit_id = (paddr[7:4] == CIR_BASE_IDENT[7:4]) && (paddr[1:0] == 2'h0);
    assign hit_data = (paddr[7:4] == CIR_BASE_DATA[7:4]) && (paddr[1:0] == 2'h0);
    assign hit_status = (paddr == CIR_OFF_STATUS);
    assign hit_any = hit_id | hit_data | hit_status;
    assign crc_ready = ~id_busy & ~data_busy & ~boot_r & ~restart_r;

    // The answer is held back while a checksum is being rebuilt, so a read
    // never returns a word whose checksum disagrees with its contents.
    assign take_nxt = psel & penable & ~pready & crc_ready;
    assign wr_fire = psel & penable & pready & pwrite;
    assign rd_fire = psel & penable & pready & ~pwrite;
    assign wr_flags = wr_fire & hit_data & (paddr[3:2] == 2'h0);

    ////////////////////////////////////////////////////////////////////////////
    // Register contents built from fixed codes and per-unit values.
    assign ident = {MAKER_CODE, APPLICATION_CODE, PRODUCT_NAME,
                    PRODUCT_REVISION, UNIT_SERIAL, 4'h0,
                    MANUFACTURE_DATE, id_crc, 1'b1};

    assign card_data = {CIR_LAYOUT_VERSION, 6'h00,
                        CIR_READ_ACCESS_TIME, CIR_READ_ACCESS_CYCLES,
                        CIR_TRANSFER_RATE, CIR_COMMAND_CLASSES,
                        CIR_BLOCK_LENGTH_CODE,
                        3'h0,
                        1'b0, 6'h00, CAPACITY, 1'b0,
                        CIR_ERASE_ENABLE, CIR_SECTOR_SIZE,
                        CIR_PROTECT_SPAN, 1'b0, 2'h0,
                        CIR_WRITE_SPEED, CIR_BLOCK_LENGTH_CODE, 1'b0, 5'h00,
                        1'b0, copy_r, perm_r, temp_r,
                        CIR_FILE_FORMAT, 2'h0, data_crc, 1'b1};

    assign status_word = {28'h0000000, write_protect, perm_lock_r, copy_lock_r,
                          crc_ready};

    // Word slicing of both registers, word 0 being the least significant.
    generate
        for (genvar i = 0; i < 4; i++) begin : g_words
            assign id_word[i] = ident[32*i +: 32];
            assign data_word[i] = card_data[32*i +: 32];
        end
    endgenerate

    // Read selection; unmapped addresses read as zero and raise an error.
    assign read_word = hit_id ? id_word[paddr[3:2]] :
                       hit_data ? data_word[paddr[3:2]] :
                       hit_status ? status_word : 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////////
    // Checksum engines. The identification checksum runs once after reset;
    // the data checksum also reruns one cycle after a flag write so that it
    // sees the new flag values.
    cir_crc7 u_id_crc (
        .clock(clock),
        .reset(reset),
        .start(boot_r),
        .message(ident[127:8]),
        .crc(id_crc),
        .busy(id_busy)
    );

    cir_crc7 u_data_crc (
        .clock(clock),
        .reset(reset),
        .start(boot_r | restart_r),
        .message(card_data[127:8]),
        .crc(data_crc),
        .busy(data_busy)
    );

    ////////////////////////////////////////////////////////////////////////////
    // APB answer: one wait state once both checksums are ready, then ready with data or error.
    always_ff @(posedge clock) begin
        if (reset) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= take_nxt;
            prdata <= (take_nxt & ~pwrite) ? read_word : 32'h0000_0000;
            pslverr <= take_nxt & ~hit_any;
        end
    end

    // Start pulses for the checksum engines.
    always_ff @(posedge clock) begin
        if (reset) begin
            boot_r <= 1'b1;
            restart_r <= 1'b0;
        end else begin
            boot_r <= 1'b0;
            restart_r <= wr_flags;
        end
    end

    // Host flags. Copy and permanent protection take the value of the first
    // write to data word 0 and then lock; the temporary bit follows every
    // write. All other words and fields ignore writes without an error.
    always_ff @(posedge clock) begin
        if (reset) begin
            copy_r <= 1'b0;
            perm_r <= 1'b0;
            temp_r <= 1'b0;
            copy_lock_r <= 1'b0;
            perm_lock_r <= 1'b0;
        end else if (wr_flags) begin
            if (!copy_lock_r) begin
                copy_r <= pwdata[CIR_COPY_BIT];
                copy_lock_r <= 1'b1;
            end
            if (!perm_lock_r) begin
                perm_r <= pwdata[CIR_PERM_BIT];
                perm_lock_r <= 1'b1;
            end
            temp_r <= pwdata[CIR_TEMP_BIT];
        end
    end

    // Either protection bit blocks writes to the card's storage.
    always_ff @(posedge clock) begin
        if (reset) begin
            write_protect <= 1'b0;
        end else begin
            write_protect <= perm_r | temp_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks on what the bank presents to the bus, on its flags and on its checksum timing.
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    logic rd_id;
    logic rd_dat;
    assign rd_id = rd_fire & hit_id;
    assign rd_dat = rd_fire & hit_data;

    a_id_readonly: assert property (
        (wr_fire & hit_id) |-> !pslverr ##1 $stable(ident))
        else $error("identification register changed after a write");

    a_id_head: assert property (
        (rd_id && paddr[3:2] == 2'h3) |->
        prdata == {MAKER_CODE, APPLICATION_CODE, PRODUCT_NAME[39:32]})
        else $error("identification head fields wrong");

    a_id_serial_date: assert property (
        (rd_id && paddr[3:2] == 2'h0) |-> prdata[31:24] == UNIT_SERIAL[7:0]
        && prdata[23:20] == 4'h0 && prdata[19:8] == MANUFACTURE_DATE)
        else $error("serial or date field wrong");

    a_id_trailer: assert property (
        (rd_id && paddr[3:2] == 2'h0) |-> prdata[0] && prdata[7:1] == id_crc)
        else $error("identification trailer wrong");

    a_crc_latency: assert property (
        boot_r |-> ##120 id_busy ##1 !id_busy)
        else $error("identification checksum took the wrong time");

    a_data_version: assert property (
        (rd_dat && paddr[3:2] == 2'h3) |-> prdata[31:30] == CIR_LAYOUT_VERSION)
        else $error("layout version wrong");

    a_data_capacity: assert property (
        (rd_dat && paddr[3:2] == 2'h1) |-> prdata[31:16] == CAPACITY[15:0])
        else $error("capacity field wrong");

    a_data_timing: assert property (
        (rd_dat && paddr[3:2] == 2'h3) |-> prdata[23:8] ==
        {CIR_READ_ACCESS_TIME, CIR_READ_ACCESS_CYCLES})
        else $error("access time fields wrong");

    a_data_classes: assert property (
        (rd_dat && paddr[3:2] == 2'h2) |-> prdata[31:20] == CIR_COMMAND_CLASSES)
        else $error("command classes wrong");

    a_block_len: assert property (
        (rd_dat && paddr[3:2] == 2'h0) |->
        prdata[25:22] == CIR_BLOCK_LENGTH_CODE && prdata[28:26] == CIR_WRITE_SPEED)
        else $error("write block length or speed factor wrong");

    a_no_partial: assert property (
        (rd_dat && paddr[3:2] == 2'h2) |-> prdata[15:12] == 4'h0)
        else $error("partial or misaligned access advertised");

    a_erase_info: assert property (
        (rd_dat && paddr[3:2] == 2'h1) |->
        prdata[14] && prdata[13:7] == CIR_SECTOR_SIZE && prdata[6:0] == 7'h00)
        else $error("erase or group size fields wrong");

    a_otp_hold: assert property (
        (wr_flags && copy_lock_r && perm_lock_r) |=> $stable(copy_r) && $stable(perm_r))
        else $error("one-time flag changed after locking");

    a_temp_follow: assert property (
        wr_flags |=> temp_r == $past(pwdata[CIR_TEMP_BIT]) ##1
        write_protect == (perm_r | $past(temp_r)))
        else $error("temporary protection did not follow the write");

    a_id_middle: assert property (
        (rd_id && paddr[3:2] == 2'h2) |-> prdata == PRODUCT_NAME[31:0])
        else $error("product name tail wrong");

    a_id_revision: assert property (
        (rd_id && paddr[3:2] == 2'h1) |-> prdata == {PRODUCT_REVISION, UNIT_SERIAL[31:8]})
        else $error("revision or serial head wrong");

    a_data_trailer: assert property (
        (rd_dat && paddr[3:2] == 2'h0) |-> prdata[0] && prdata[7:1] == data_crc)
        else $error("data register trailer wrong");

    a_group_off: assert property (
        (rd_dat && paddr[3:2] == 2'h0) |-> !prdata[31] && prdata[30:29] == 2'h0)
        else $error("group write protection advertised");

    a_format_clear: assert property (
        (rd_dat && paddr[3:2] == 2'h0) |-> !prdata[CIR_FORMAT_BIT] && prdata[11:8] == 4'h0)
        else $error("format group or file format not clear");

    // A busy checksum must hold the answer back, or a read could see a stale code.
    a_busy_hold: assert property (
        !crc_ready |=> !pready)
        else $error("answer given while a checksum was busy");

    a_err_unmapped: assert property (
        (pready && psel) |-> pslverr == !hit_any)
        else $error("error flag disagrees with the address map");

    c_read_ident: cover property (rd_id && paddr[3:2] == 2'h3);
    c_flag_write: cover property (wr_flags ##1 restart_r ##[1:130] crc_ready);
    c_unmapped: cover property (pready && pslverr);

endmodule : cir_regs

/* bench/cir_host_model.sv */
/*
 * Host side model: an APB master that stands in for the card controller
 * and reaches the register bank word by word.
 * Assumes the bank shares its clock; the bench calls xfer hierarchically.
 */
module cir_host_model (
    input wire logic clock, // System clock.
    output logic psel, // APB select.
    output logic penable, // APB access phase.
    output logic pwrite, // APB direction, high for write.
    output logic [7:0] paddr, // APB byte address.
    output logic [31:0] pwdata, // APB write data.
    input wire logic pready, // APB ready from the bank.
    input wire logic [31:0] prdata, // APB read data from the bank.
    input wire logic pslverr // APB error from the bank.
);
    timeunit 1ns;
    timeprecision 1ps;

    ////////////////////////////////////////////////////////////////////////////
    // Idle bus at time zero, so no input of the bank starts unknown.
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
    end

    // One transfer. The request is held until pready is sampled high; the
    // released lines show the inverse so stale values cannot pass for data.
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~wd;
    endtask : xfer
endmodule : cir_host_model

/* bench/cir_regs_tb_top.sv */
/*
 * Self-checking bench for the card identification and card data bank.
 * Assumes the host model drives APB and the bench owns clock and reset.
 */
module cir_regs_tb_top
    import cir_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;

    // Production values chosen for this run; identity codes are arbitrary.
    localparam logic [7:0] T_MAKER = 8'hA7;
    localparam logic [15:0] T_APP = 16'h1C2D;
    localparam logic [39:0] T_NAME = 40'h51_52_53_54_55;
    localparam logic [7:0] T_REV = 8'h22;
    localparam logic [31:0] T_SERIAL = 32'h1234_5678;
    localparam logic [11:0] T_DATE = 12'h7B3;
    localparam logic [21:0] T_CAP = 22'h00749F;
    localparam int LIMIT = 20000;

    logic clock = 1'b0;
    logic reset;
    logic psel, penable, pwrite, pready, pslverr, wp;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    int err_count = 0;
    int n_tests = 0;
    int cycles = 0;
    logic [127:0] v;

    ////////////////////////////////////////////////////////////////////////////
    // Clock at 40 MHz.
    always #12.5 clock = ~clock;

    cir_regs #(.MAKER_CODE(T_MAKER), .APPLICATION_CODE(T_APP), .PRODUCT_NAME(T_NAME),
        .PRODUCT_REVISION(T_REV), .UNIT_SERIAL(T_SERIAL), .MANUFACTURE_DATE(T_DATE),
        .CAPACITY(T_CAP)) dut_u (.clock(clock), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .write_protect(wp));

    cir_host_model host_u (.clock(clock), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr));

    ////////////////////////////////////////////////////////////////////////////
    // Bench side checksum, written apart from the bank so a shared slip cannot hide.
    function automatic logic [6:0] crc7(input logic [119:0] m);
        logic [6:0] c;
        logic fb;
        c = 7'h00;
        for (int i = 119; i >= 0; i--) begin
            fb = c[6] ^ m[i];
            c = {c[5:0], 1'b0};
            if (fb) c = c ^ 7'h09;
        end
        return c;
    endfunction : crc7

    // Expected identification image from the production values.
    function automatic logic [127:0] exp_ident();
        cir_ident_s s;
        s = '0;
        s.maker_code = T_MAKER;
        s.application_code = T_APP;
        s.product_name = T_NAME;
        s.product_revision = T_REV;
        s.unit_serial = T_SERIAL;
        s.manufacture_date = T_DATE;
        s.crc = crc7(s[127:8]);
        s.fixed_one = 1'b1;
        return s;
    endfunction : exp_ident

    // Expected card data image for given copy, permanent and temporary flags.
    function automatic logic [127:0] exp_data(input logic cp, input logic pm, input logic tp);
        cir_data_s s;
        s = '0;
        s.layout_version = 2'h1;
        s.read_access_time_code = 8'h0E;
        s.max_transfer_rate = 8'h5A;
        s.supported_command_classes = 12'h5B5;
        s.max_read_block_length = 4'h9;
        s.capacity = T_CAP;
        s.single_block_erase_enable = 1'b1;
        s.erase_sector_size = 7'h7F;
        s.write_speed_factor = 3'h2;
        s.max_write_block_length = 4'h9;
        s.copy_flag = cp;
        s.permanent_protection = pm;
        s.temporary_protection = tp;
        s.crc = crc7(s[127:8]);
        s.fixed_one = 1'b1;
        return s;
    endfunction : exp_data

    ////////////////////////////////////////////////////////////////////////////
    // Compare tasks, one per kind of result.
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk32

    task automatic chk1(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk1

    // Bus helpers built on the host model.
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic eerr);
        logic [31:0] d;
        logic e;
        host_u.xfer(1'b0, a, 32'h0000_0000, d, e);
        chk32(d, exp);
        chk1(e, eerr);
    endtask : rd_chk

    task automatic wr(input logic [7:0] a, input logic [31:0] wd, input logic eerr);
        logic [31:0] d;
        logic e;
        host_u.xfer(1'b1, a, wd, d, e);
        chk1(e, eerr);
    endtask : wr

    task automatic rd_reg(input logic [7:0] base, input logic [127:0] exp);
        for (int k = 0; k < 4; k++) rd_chk(base + 8'(4 * k), exp[32 * k +: 32], 1'b0);
    endtask : rd_reg

    // The protect output settles two cycles after the write is answered; the check waits four.
    task automatic wp_chk(input logic exp);
        repeat (4) @(negedge clock);
        chk1(wp, exp);
    endtask : wp_chk

    task automatic give_verdict();
        $display("compares %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict

    ////////////////////////////////////////////////////////////////////////////
    // Hang guard; the ceiling is more than ten times the expected run length.
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            err_count++;
            give_verdict();
        end
    end

    // Main sequence of tests.
    initial begin
        reset = 1'b1;
        repeat (2) @(posedge clock);
        chk1(wp, 1'b0);
        reset <= 1'b0;
        rd_chk(CIR_OFF_STATUS, 32'h0000_0001, 1'b0);
        rd_reg(CIR_BASE_IDENT, exp_ident());
        v = exp_data(1'b0, 1'b0, 1'b0);
        rd_reg(CIR_BASE_DATA, v);
        $display("test delivery_values done");
        // Writes to fixed words must leave everything as delivered.
        wr(8'h00, 32'hFFFF_FFFF, 1'b0);
        wr(8'h0C, 32'h0000_0000, 1'b0);
        wr(8'h14, 32'hFFFF_FFFF, 1'b0);
        wr(8'h1C, 32'h0000_0000, 1'b0);
        wr(CIR_OFF_STATUS, 32'h0000_000E, 1'b0);
        rd_reg(CIR_BASE_IDENT, exp_ident());
        rd_reg(CIR_BASE_DATA, exp_data(1'b0, 1'b0, 1'b0));
        rd_chk(CIR_OFF_STATUS, 32'h0000_0001, 1'b0);
        $display("test read_only done");
        // Unmapped and misaligned places answer with an error.
        wr(8'h40, 32'hFFFF_FFFF, 1'b1);
        rd_chk(8'h24, 32'h0000_0000, 1'b1);
        rd_chk(8'h02, 32'h0000_0000, 1'b1);
        rd_chk(8'hFC, 32'h0000_0000, 1'b1);
        $display("test unmapped done");
        // First flag write programs copy once; permanent is locked at zero.
        wr(CIR_BASE_DATA, 32'hFFFF_DFFF, 1'b0);
        wp_chk(1'b1);
        rd_reg(CIR_BASE_DATA, exp_data(1'b1, 1'b0, 1'b1));
        rd_chk(CIR_OFF_STATUS, 32'h0000_000F, 1'b0);
        wr(CIR_BASE_DATA, 32'h0000_2000, 1'b0);
        wp_chk(1'b0);
        rd_reg(CIR_BASE_DATA, exp_data(1'b1, 1'b0, 1'b0));
        rd_chk(CIR_OFF_STATUS, 32'h0000_0007, 1'b0);
        wr(CIR_BASE_DATA, 32'h0000_1000, 1'b0);
        wp_chk(1'b1);
        v = exp_data(1'b1, 1'b0, 1'b1);
        rd_chk(CIR_BASE_DATA, v[31:0], 1'b0);
        $display("test one_time_flags done");
        // A reset in mid-run returns to delivery; permanent then programs to one.
        @(posedge clock);
        reset <= 1'b1;
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        wp_chk(1'b0);
        rd_chk(CIR_OFF_STATUS, 32'h0000_0001, 1'b0);
        rd_reg(CIR_BASE_DATA, exp_data(1'b0, 1'b0, 1'b0));
        wr(CIR_BASE_DATA, 32'h0000_2000, 1'b0);
        wp_chk(1'b1);
        rd_reg(CIR_BASE_DATA, exp_data(1'b0, 1'b1, 1'b0));
        rd_chk(CIR_OFF_STATUS, 32'h0000_000F, 1'b0);
        wr(CIR_BASE_DATA, 32'h0000_4000, 1'b0);
        wp_chk(1'b1);
        v = exp_data(1'b0, 1'b1, 1'b0);
        rd_chk(CIR_BASE_DATA, v[31:0], 1'b0);
        $display("test second_reset done");
        give_verdict();
    end
endmodule : cir_regs_tb_top
